/* File: sphw_pkg.sv */
// package: constants and carrier types for the sleep/pause/wake halt control
`default_nettype none
package sphw_pkg;
	localparam logic [4:0] SPHW_OP_SLEEP     = 5'h10;
	localparam logic [4:0] SPHW_OP_HIBERNATE = 5'h08;
	localparam logic [4:0] SPHW_OP_SUSPEND   = 5'h18;
	localparam logic [1:0] SPHW_RMODE_SLEEP  = 2'h1;
	localparam int         SPHW_SYNC_STAGES  = 2;
	localparam logic       SPHW_CLKEN_RESET  = 1'h1;

	typedef enum logic [2:0] {
		SPHW_RUN       = 3'h0,
		SPHW_SLP_DRAIN = 3'h1,
		SPHW_SLEEPING  = 3'h2,
		SPHW_PS_DRAIN  = 3'h3,
		SPHW_PAUSED    = 3'h4
	} sphw_state_t;

	typedef struct packed {
		logic sleep;
		logic hibernate;
		logic suspend;
	} sphw_halt_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] operand;
	} sphw_barrier_t;
endpackage
`default_nettype wire

/* File: sphw_sync.sv */
// optional multi-stage synchroniser with bypass
`timescale 1ns/1ps
`default_nettype none
module sphw_sync #(
	parameter int   STAGES = 2,
	parameter logic INIT   = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic d_i,
	output logic      q_o
);
	generate
		if (STAGES == 0) begin : g_bypass
			assign q_o = d_i;
		end else begin : g_chain
			logic [STAGES-1:0] chain_q;
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					chain_q <= {STAGES{INIT}};
				end else begin
					// cast keeps a single-stage chain legal
					chain_q <= STAGES'({chain_q, d_i});
				end
			end
			assign q_o = chain_q[STAGES-1];
		end
	endgenerate
endmodule
`default_nettype wire

/* File: sphw_clk_gate.sv */
// example clock-enable flop for an external clock controller
`timescale 1ns/1ps
`default_nettype none
module sphw_clk_gate (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic sleep_i,
	input  wire logic irq_i,
	input  wire logic dbg_wake_i,
	output logic      clk_en_o
);
	logic en_q;
	// synchronous reset like the partner's flop; power-up value set
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			en_q <= sphw_pkg::SPHW_CLKEN_RESET;
		end else if (sleep_i && !irq_i && !dbg_wake_i) begin
			en_q <= 1'b0;
		end else if (!en_q) begin
			en_q <= 1'b1;
		end
	end
	assign clk_en_o = en_q;
endmodule
`default_nettype wire

/* File: sphw_halt_ctrl.sv */
// sleep, hibernate, suspend and pause halt control of the processor core
`timescale 1ns/1ps
`default_nettype none
// Function
// - interrupt input synchronised only when irq_sync_enable is set
// - reset passes sync_stage_count flops, default 2; zero means synchronous reset
// - each wake-up input synchronised when its wake_sync_enable bit is set
// - debug wake latched on the update strobe rising edge when serial, else sampled every processor clock
// - sleep barrier: drain accesses, halt, assert exactly one halt output
// - operand 16 sleep, 8 hibernate, 24 suspend
// - in sleep, either wake-up input high resumes after the barrier
// - pause high: drain accesses, halt, assert pause acknowledge
// - pause low: resume exactly where paused
// - pause, acknowledge and debug continue all on processor clock
// - wake-up inputs ignored outside sleep mode
// - reset mode 01 enters sleep at once; wake starts at reset vector
module sphw_halt_ctrl #(
	parameter logic       IRQ_SYNC_ENABLE  = 1'b1,
	parameter int         SYNC_STAGE_COUNT = sphw_pkg::SPHW_SYNC_STAGES,
	parameter logic [1:0] WAKE_SYNC_ENABLE = 2'h3,
	parameter logic       DEBUG_INTERFACE  = 1'b0
) (
	input  wire logic       CLOCK_I,
	input  wire logic       RSTN_I,
	input  wire logic       RESET_I,
	input  wire logic [1:0] RESET_MODE_I,
	input  wire logic       IRQ_I,
	input  wire logic [1:0] WAKE_I,
	input  wire logic       BARRIER_VALID_I,
	input  wire logic [4:0] BARRIER_OP_I,
	input  wire logic       ACCESS_BUSY_I,
	input  wire logic       PAUSE_I,
	input  wire logic       DBG_UPDATE_I,
	input  wire logic       DBG_WAKE_REQ_I,
	input  wire logic       DBG_CONT_REQ_I,
	output logic            IRQ_O,
	output logic            CORE_RESET_O,
	output logic            HALT_O,
	output logic            RESUME_O,
	output logic            START_AT_VECTOR_O,
	output logic            SLEEP_O,
	output logic            HIBERNATE_O,
	output logic            SUSPEND_O,
	output logic            PAUSE_ACK_O,
	output logic            DBG_WAKE_O,
	output logic            DBG_CONTINUE_O,
	output logic            CLK_EN_O
);
	sphw_pkg::sphw_state_t   state_q;
	sphw_pkg::sphw_state_t   state_d;
	sphw_pkg::sphw_halt_t    halt_q;
	sphw_pkg::sphw_halt_t    halt_d;
	sphw_pkg::sphw_halt_t    halt_sel;
	sphw_pkg::sphw_halt_t    pend_q;
	sphw_pkg::sphw_barrier_t bar;
	logic                    reset_s;
	logic                    irq_s;
	logic [1:0]              wake_s;
	logic                    wake_any;
	logic                    rmode_sleep_q;
	logic                    vector_q;
	logic                    resume_q;
	logic                    dbg_upd_q;
	logic                    dbg_wake_q;
	logic                    cont_q;

	assign bar = '{valid: BARRIER_VALID_I, operand: BARRIER_OP_I};

	// reset may be asynchronous to the clock, so it is chained too
	sphw_sync #(
		.STAGES(SYNC_STAGE_COUNT),
		.INIT  (1'b1)
	) u_rst_sync (
		.clk_i  (CLOCK_I),
		.rst_n_i(RSTN_I),
		.d_i    (RESET_I),
		.q_o    (reset_s)
	);

	sphw_sync #(
		.STAGES(IRQ_SYNC_ENABLE ? sphw_pkg::SPHW_SYNC_STAGES : 0),
		.INIT  (1'b0)
	) u_irq_sync (
		.clk_i  (CLOCK_I),
		.rst_n_i(RSTN_I),
		.d_i    (IRQ_I),
		.q_o    (irq_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_wake
			sphw_sync #(
				.STAGES(WAKE_SYNC_ENABLE[gi] ? SYNC_STAGE_COUNT : 0),
				.INIT  (1'b0)
			) u_wake_sync (
				.clk_i  (CLOCK_I),
				.rst_n_i(RSTN_I),
				.d_i    (WAKE_I[gi]),
				.q_o    (wake_s[gi])
			);
		end
	endgenerate

	assign wake_any = |wake_s;
	assign IRQ_O    = irq_s;
	assign CORE_RESET_O = reset_s;

	// operand decode; unknown operands are not sleep barriers
	always_comb begin
		halt_sel = '0;
		unique case (bar.operand)
			sphw_pkg::SPHW_OP_SLEEP:     halt_sel.sleep     = 1'b1;
			sphw_pkg::SPHW_OP_HIBERNATE: halt_sel.hibernate = 1'b1;
			sphw_pkg::SPHW_OP_SUSPEND:   halt_sel.suspend   = 1'b1;
			default:                     halt_sel           = '0;
		endcase
	end

	always_comb begin
		state_d = state_q;
		halt_d  = halt_q;
		unique case (state_q)
			sphw_pkg::SPHW_RUN: begin
				// pause takes priority over a barrier in the same cycle
				if (PAUSE_I) begin
					state_d = sphw_pkg::SPHW_PS_DRAIN;
				end else if (bar.valid && (halt_sel != '0)) begin
					state_d = sphw_pkg::SPHW_SLP_DRAIN;
					halt_d  = halt_sel;
				end
			end
			sphw_pkg::SPHW_SLP_DRAIN: begin
				if (!ACCESS_BUSY_I) begin
					state_d = sphw_pkg::SPHW_SLEEPING;
					halt_d  = pend_q;
				end
			end
			sphw_pkg::SPHW_SLEEPING: begin
				if (wake_any) begin
					state_d = sphw_pkg::SPHW_RUN;
					halt_d  = '0;
				end
			end
			sphw_pkg::SPHW_PS_DRAIN: begin
				if (!ACCESS_BUSY_I) begin
					state_d = sphw_pkg::SPHW_PAUSED;
				end
			end
			sphw_pkg::SPHW_PAUSED: begin
				if (!PAUSE_I) begin
					state_d = sphw_pkg::SPHW_RUN;
				end
			end
			default: begin
				state_d = sphw_pkg::SPHW_RUN;
				halt_d  = '0;
			end
		endcase
	end

	// reset mode sampled while reset is held
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rmode_sleep_q <= 1'b0;
		end else if (reset_s) begin
			rmode_sleep_q <= (RESET_MODE_I == sphw_pkg::SPHW_RMODE_SLEEP);
		end else if (state_q == sphw_pkg::SPHW_SLEEPING && wake_any) begin
			// only the first wake after a strapped reset goes to the vector
			rmode_sleep_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q <= sphw_pkg::SPHW_RUN;
			halt_q  <= '0;
		end else if (reset_s) begin
			// no bus access: go straight to sleeping when strapped
			if (RESET_MODE_I == sphw_pkg::SPHW_RMODE_SLEEP) begin
				state_q <= sphw_pkg::SPHW_SLEEPING;
				halt_q  <= '{sleep: 1'b1, hibernate: 1'b0, suspend: 1'b0};
			end else begin
				state_q <= sphw_pkg::SPHW_RUN;
				halt_q  <= '0;
			end
		end else begin
			state_q <= state_d;
			halt_q  <= (state_d == sphw_pkg::SPHW_SLEEPING) ? halt_d : '0;
		end
	end

	// remember pending selection while draining; outputs stay low meanwhile
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pend_q <= '0;
		end else if (state_q == sphw_pkg::SPHW_RUN && state_d == sphw_pkg::SPHW_SLP_DRAIN) begin
			pend_q <= halt_sel;
		end
	end

	// wake from a reset-mode sleep restarts at the vector
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			vector_q <= 1'b0;
			resume_q <= 1'b0;
		end else if (reset_s) begin
			vector_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			vector_q <= rmode_sleep_q && (state_q == sphw_pkg::SPHW_SLEEPING) && wake_any;
			resume_q <= (state_q == sphw_pkg::SPHW_SLEEPING && wake_any)
				|| (state_q == sphw_pkg::SPHW_PAUSED && !PAUSE_I);
		end
	end

	// debug wake: serial form is held from the update strobe; wake inputs
	// are only looked at in the sleeping state, so others are ignored
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			dbg_upd_q  <= 1'b0;
			dbg_wake_q <= 1'b0;
			cont_q     <= 1'b0;
		end else begin
			dbg_upd_q <= DBG_UPDATE_I;
			if (DEBUG_INTERFACE) begin
				dbg_wake_q <= DBG_WAKE_REQ_I;
			end else if (DBG_UPDATE_I && !dbg_upd_q) begin
				dbg_wake_q <= DBG_WAKE_REQ_I;
			end
			cont_q <= DBG_CONT_REQ_I && (state_q == sphw_pkg::SPHW_PAUSED);
		end
	end

	sphw_clk_gate u_clk_gate (
		.clk_i     (CLOCK_I),
		.reset_i   (reset_s),
		.sleep_i   (SLEEP_O),
		.irq_i     (irq_s),
		.dbg_wake_i(dbg_wake_q),
		.clk_en_o  (CLK_EN_O)
	);

	assign SLEEP_O           = halt_q.sleep;
	assign HIBERNATE_O       = halt_q.hibernate;
	assign SUSPEND_O         = halt_q.suspend;
	assign PAUSE_ACK_O       = (state_q == sphw_pkg::SPHW_PAUSED);
	assign HALT_O            = (state_q != sphw_pkg::SPHW_RUN);
	assign RESUME_O          = resume_q;
	assign START_AT_VECTOR_O = vector_q;
	assign DBG_WAKE_O        = dbg_wake_q;
	assign DBG_CONTINUE_O    = cont_q;
endmodule
`default_nettype wire

/* File: sphw_props.sv */
// checker for the halt control ports
`timescale 1ns/1ps
`default_nettype none
module sphw_props (
	input wire logic       CLOCK_I,
	input wire logic       RSTN_I,
	input wire logic [1:0] WAKE_I,
	input wire logic       BARRIER_VALID_I,
	input wire logic [4:0] BARRIER_OP_I,
	input wire logic       ACCESS_BUSY_I,
	input wire logic       PAUSE_I,
	input wire logic       CORE_RESET_O,
	input wire logic       HALT_O,
	input wire logic       RESUME_O,
	input wire logic       SLEEP_O,
	input wire logic       HIBERNATE_O,
	input wire logic       SUSPEND_O,
	input wire logic       PAUSE_ACK_O
);
	logic [4:0] op_q;
	logic [2:0] halt;
	assign halt = {SLEEP_O, HIBERNATE_O, SUSPEND_O};
	// last barrier accepted while running
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			op_q <= 5'h00;
		end else if (BARRIER_VALID_I && !HALT_O && !PAUSE_I) begin
			op_q <= BARRIER_OP_I;
		end
	end
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I || CORE_RESET_O);
	a_halt_one_hot: assert property (
		$onehot0(halt)) else $error("two halt outputs");
	a_op_decode: assert property (
		$rose(|halt) |-> halt == {op_q == 5'h10, op_q == 5'h08, op_q == 5'h18})
		else $error("wrong halt output");
	a_pause_drain: assert property (
		$rose(PAUSE_ACK_O) |-> !$past(ACCESS_BUSY_I) && $past(PAUSE_I)) else $error("early ack");
	a_ack_holds: assert property (
		PAUSE_ACK_O && PAUSE_I |=> PAUSE_ACK_O) else $error("ack dropped");
	a_pause_release: assert property (
		PAUSE_ACK_O && !PAUSE_I |=> !PAUSE_ACK_O && RESUME_O) else $error("no resume");
	a_wake_leave: assert property (
		(|halt) && WAKE_I != 2'h0 |-> ##[1:4] !HALT_O) else $error("wake missed");
	a_run_no_resume: assert property (
		!HALT_O |=> !RESUME_O) else $error("resume while running");
	a_resume_ends_halt: assert property (
		$fell(HALT_O) |-> RESUME_O) else $error("halt left silently");
	c_suspend: cover property ($rose(SUSPEND_O));
	c_unpause: cover property ($fell(PAUSE_ACK_O));
	c_wake: cover property ($fell(SLEEP_O) && RESUME_O);
endmodule
bind sphw_halt_ctrl sphw_props props (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .WAKE_I(WAKE_I),
	.BARRIER_VALID_I(BARRIER_VALID_I), .BARRIER_OP_I(BARRIER_OP_I),
	.ACCESS_BUSY_I(ACCESS_BUSY_I), .PAUSE_I(PAUSE_I), .CORE_RESET_O(CORE_RESET_O),
	.HALT_O(HALT_O), .RESUME_O(RESUME_O), .SLEEP_O(SLEEP_O), .HIBERNATE_O(HIBERNATE_O),
	.SUSPEND_O(SUSPEND_O), .PAUSE_ACK_O(PAUSE_ACK_O));
`default_nettype wire

/* File: sphw_ext_ctrl.sv */
// model of the outside wake and pause controller
`timescale 1ns/1ps
`default_nettype none
module sphw_ext_ctrl (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       irq_i,
	input  wire logic       dbg_wake_i,
	input  wire logic       dbg_cont_i,
	input  wire logic       pause_ack_i,
	input  wire logic       pause_req_i,
	output logic      [1:0] wake_o,
	output logic            pause_o
);
	logic pause_q;
	logic req_q;
	assign wake_o = {dbg_wake_i, irq_i};
	assign pause_o = pause_q;
	// pause only moves once the ack has followed it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pause_q <= 1'b0;
			req_q <= 1'b0;
		end else begin
			req_q <= pause_req_i;
			if (!pause_q && !pause_ack_i && pause_req_i && !req_q) begin
				pause_q <= 1'b1;
			end else if (pause_q && pause_ack_i && (dbg_cont_i || !pause_req_i)) begin
				pause_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sphw_tb.sv */
// self-checking bench for the halt control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
`define WAITF(c) begin n = 0; while (!(c) && n < 30) begin @(posedge clk); #1; n++; end end
module testbench;
	logic       clk, rstn, rst, irq, bvalid, busy, pause_req, dupd, dwreq, dcreq, pause;
	logic       irq_s, core_rst, halt, resume, vec, slp, hib, sus, ack, dwake, dcont, clken;
	logic [1:0] rmode, wake;
	logic [4:0] bop;
	logic [4:0] ops [4] = '{5'h10, 5'h08, 5'h18, 5'h04};
	logic [2:0] exps [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
	int         error_cnt = 0;
	int         comparisons = 0;
	int         n;
	always #12.5 clk = ~clk;
	sphw_halt_ctrl uut (.CLOCK_I(clk), .RSTN_I(rstn), .RESET_I(rst), .RESET_MODE_I(rmode),
		.IRQ_I(irq), .WAKE_I(wake), .BARRIER_VALID_I(bvalid), .BARRIER_OP_I(bop),
		.ACCESS_BUSY_I(busy), .PAUSE_I(pause), .DBG_UPDATE_I(dupd), .DBG_WAKE_REQ_I(dwreq),
		.DBG_CONT_REQ_I(dcreq), .IRQ_O(irq_s), .CORE_RESET_O(core_rst), .HALT_O(halt),
		.RESUME_O(resume), .START_AT_VECTOR_O(vec), .SLEEP_O(slp), .HIBERNATE_O(hib),
		.SUSPEND_O(sus), .PAUSE_ACK_O(ack), .DBG_WAKE_O(dwake), .DBG_CONTINUE_O(dcont),
		.CLK_EN_O(clken));
	sphw_ext_ctrl ext (.clk_i(clk), .rst_n_i(rstn), .irq_i(irq), .dbg_wake_i(dwake),
		.dbg_cont_i(dcont), .pause_ack_i(ack), .pause_req_i(pause_req), .wake_o(wake),
		.pause_o(pause));
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// serial debug wake moves only on an update strobe
	task upd(input logic r);
		@(posedge clk);
		dwreq <= r;
		@(posedge clk);
		dupd <= 1'b1;
		@(posedge clk);
		dupd <= 1'b0;
		#1;
	endtask
	task end_sim;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#100us;
		error_cnt++;
		end_sim();
	end
	initial begin
		{clk, rstn, irq, bvalid, busy, pause_req, dupd, dwreq, dcreq} = 9'h000;
		rst = 1'b1;
		rmode = 2'h1;
		bop = 5'h00;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		`CHK("core_rst", 1'b1, core_rst)
		tick(1);
		`CHK("core_rst", 1'b0, core_rst)
		tick(3);
		`CHK("mode_sleep", 1'b1, slp)
		`CHK("clk_en", 1'b0, clken)
		upd(1'b1);
		`WAITF(resume)
		`CHK("dbg_wake", 1'b1, dwake)
		`CHK("vector", 1'b1, vec)
		upd(1'b0);
		tick(3);
		`CHK("run_wake", 1'b0, halt)
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			bvalid <= 1'b1;
			bop <= ops[i];
			busy <= 1'b1;
			@(posedge clk);
			bvalid <= 1'b0;
			tick(3);
			`CHK("busy_halt", 3'h0, {slp, hib, sus})
			@(posedge clk);
			busy <= 1'b0;
			tick(3);
			`CHK("halt_out", exps[i], {slp, hib, sus})
			`CHK("clk_en", ~exps[i][2], clken)
			@(posedge clk);
			irq <= 1'b1;
			`WAITF(resume)
			`CHK("resume", |exps[i], resume)
			`CHK("no_vector", 1'b0, vec)
			`CHK("irq_sync", 1'b1, irq_s)
			@(posedge clk);
			irq <= 1'b0;
		end
		@(posedge clk);
		busy <= 1'b1;
		pause_req <= 1'b1;
		tick(4);
		`CHK("ack_busy", 1'b0, ack)
		@(posedge clk);
		busy <= 1'b0;
		`WAITF(ack)
		`CHK("ack", 1'b1, ack)
		@(posedge clk);
		dcreq <= 1'b1;
		tick(2);
		`CHK("continue", 1'b1, dcont)
		`WAITF(resume)
		`CHK("unpause", 2'h2, {resume, ack})
		@(posedge clk);
		rst <= 1'b1;
		rmode <= 2'h0;
		tick(3);
		`CHK("core_rst", 1'b1, core_rst)
		@(posedge clk);
		rst <= 1'b0;
		tick(3);
		`CHK("mode_run", 3'h0, {core_rst, halt, slp})
		end_sim();
	end
endmodule
`default_nettype wire
